// ---- rtl/acc_ctrl.sv ----
// serial interface and conversion sequencer of the converter control side
`include "acc_regs.svh"
module acc_ctrl import acc_pkg::*; #(
  parameter int TIMEOUT_CYC = `ACC_TIMEOUT_CYC,
  parameter int CONV_CYC = `ACC_CONV_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  input wire logic RESET_N_I,
  input wire logic START_I,
  input wire logic TIMEOUT_EN_I,
  input wire logic CONT_MODE_I,
  output logic DOUT_DONE_O,
  output logic DOUT_DONE_OE_N_O,
  output logic DONE_FLAG_O
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int CW = $clog2(CONV_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  acc_pins_t pins_raw; // raw host pins
  acc_pins_t ser;      // synchronised copy
  assign pins_raw = '{sclk: SCLK_I, cs_n: CS_N_I, din: DIN_I, rst_n: RESET_N_I,
                      start: START_I, to_en: TIMEOUT_EN_I, cont: CONT_MODE_I};

  acc_sync #(.W($bits(acc_pins_t)), .RST_VAL(`ACC_PIN_RST)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .d_i(pins_raw),
    .q_o(ser)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial interface
  logic sclk_q;          // previous synced serial clock
  logic start_q;         // previous synced start pin
  logic [5:0] bit_cnt;   // bits seen in this frame
  logic [7:0] cmd_sh;    // command shift register
  logic [23:0] out_sh;   // read data shift register
  logic dout_bit;        // data bit on the pin during a read
  logic in_cmd;          // between first rise and last fall of a frame
  logic rd_mode;         // data phase of a read command
  logic [TW-1:0] to_cnt; // cycles since the last serial clock edge
  logic [23:0] result;   // latest conversion result

  wire sclk_rise = ser.sclk & ~sclk_q;
  wire sclk_fall = ~ser.sclk & sclk_q;
  wire sclk_edge = sclk_rise | sclk_fall;
  wire timeout_hit = ser.to_en && !ser.cs_n && (to_cnt == TW'(TIMEOUT_CYC - 1));
  // chip select high or a stalled clock drops the frame
  wire iface_rst = ser.cs_n | timeout_hit;
  wire [7:0] cmd_byte = {cmd_sh[6:0], ser.din};
  wire cmd_done = !iface_rst && sclk_fall && in_cmd && !rd_mode
                  && (bit_cnt == 6'(`ACC_CMD_BITS - 1));
  wire last_data = sclk_fall && rd_mode
                   && (bit_cnt == 6'(`ACC_CMD_BITS + `ACC_DATA_BITS - 1));
  wire cmd_start = cmd_done && (cmd_byte == `ACC_OP_START);
  wire cmd_stop = cmd_done && (cmd_byte == `ACC_OP_STOP);
  wire cmd_reset = cmd_done && (cmd_byte == `ACC_OP_RESET);
  wire cmd_read = cmd_done && (cmd_byte == `ACC_OP_READ);

  // time-out counter, counts only a stall inside chip select
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      to_cnt <= '0;
    // RULE13: restart on edges, cs
    end else if (ser.cs_n || sclk_edge || timeout_hit) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= to_cnt + TW'(1);
    end
  end

  // frame tracking, command capture and data shifting
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_q <= 1'b0;
      bit_cnt <= '0;
      cmd_sh <= '0;
      out_sh <= '0;
      dout_bit <= 1'b0;
      in_cmd <= 1'b0;
      rd_mode <= 1'b0;
    end else begin
      sclk_q <= ser.sclk;
      // RULE1: stall and RULE3: cs reset
      if (iface_rst) begin
        bit_cnt <= '0;
        in_cmd <= 1'b0;
        rd_mode <= 1'b0;
      end else if (sclk_rise) begin
        in_cmd <= 1'b1;           // first rise opens the frame
        if (rd_mode) begin
          dout_bit <= out_sh[23];
          out_sh <= {out_sh[22:0], 1'b0};
        end
      end else if (sclk_fall && in_cmd) begin
        // RULE4: capture on falling edge
        cmd_sh <= cmd_byte;
        bit_cnt <= bit_cnt + 6'h01;
        if (cmd_read) begin
          rd_mode <= 1'b1;
          out_sh <= result;
        end else if (cmd_done || last_data) begin
          in_cmd <= 1'b0;         // last fall closes the frame
          rd_mode <= 1'b0;
          bit_cnt <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  acc_state_t state;      // sequencer state
  logic [9:0] settle_cnt; // cycles since reset release
  logic [CW-1:0] conv_cnt;// cycles into the conversion
  logic [7:0] win_cnt;    // cycles since done flag fell
  logic done_flag;        // high while busy, low when data ready
  logic run_by_pin;       // run was started by the start pin
  logic stop_pend;        // stop seen during a conversion

  wire soft_rst = !ser.rst_n || cmd_reset;
  wire settled = (settle_cnt == 10'(`ACC_SETTLE_CYC));
  wire start_rise = ser.start & ~start_q;
  wire start_req = start_rise || cmd_start;
  // a pin-started run is stopped by the pin going low
  wire stop_lvl = cmd_stop || (run_by_pin && !ser.start) || !ser.cont;
  wire conv_end = (conv_cnt == CW'(CONV_CYC - 1));
  // window stretched by the pin latency, so a stop at the window's far edge still cancels
  wire win_end = (win_cnt == 8'(`ACC_STOP_WIN + `ACC_SYNC_LAT - 1));

  // sequencer: settle, idle, convert, stop window
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= ST_SETTLE;
      settle_cnt <= '0;
      conv_cnt <= '0;
      win_cnt <= '0;
      done_flag <= 1'b1;
      run_by_pin <= 1'b0;
      stop_pend <= 1'b0;
      start_q <= 1'b0;
      result <= '0;
    end else begin
      start_q <= ser.start;
      if (soft_rst) begin
        state <= ST_SETTLE;
        settle_cnt <= '0;
        done_flag <= 1'b1;
      end else begin
        case (state)
          // RULE10: settle before converting
          ST_SETTLE: begin
            if (settled) begin
              state <= ST_IDLE;
            end else begin
              settle_cnt <= settle_cnt + 10'h001;
            end
          end
          ST_IDLE: begin
            // RULE11: flag rises next edge
            if (start_req) begin
              state <= ST_CONV;
              done_flag <= 1'b1;
              conv_cnt <= '0;
              stop_pend <= 1'b0;
              run_by_pin <= start_rise;
            end
          end
          ST_CONV: begin
            conv_cnt <= conv_cnt + CW'(1);
            if (stop_lvl) begin
              stop_pend <= 1'b1;
            end
            // RULE9: high for the whole conversion
            if (conv_end) begin
              done_flag <= 1'b0;
              result <= result + 24'h000001;
              win_cnt <= '0;
              state <= (ser.cont && !stop_pend && !stop_lvl) ? ST_WINDOW : ST_IDLE;
            end
          end
          ST_WINDOW: begin
            win_cnt <= win_cnt + 8'h01;
            // RULE7: early stop cancels
            if (stop_lvl) begin
              state <= ST_IDLE;
            // RULE8: window closed, next runs
            end else if (win_end) begin
              state <= ST_CONV;
              done_flag <= 1'b1;
              conv_cnt <= '0;
              stop_pend <= 1'b0;
            end
          end
          default: state <= ST_SETTLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DOUT_DONE_O <= 1'b1;
      DOUT_DONE_OE_N_O <= 1'b1;
      DONE_FLAG_O <= 1'b1;
    end else begin
      // RULE12: done flag outside a frame
      DOUT_DONE_O <= in_cmd ? dout_bit : done_flag;
      DOUT_DONE_OE_N_O <= ser.cs_n;
      DONE_FLAG_O <= done_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [5:0] hi_cnt;  // consecutive flag-high cycles, saturating
  logic [9:0] idle_cnt;// cycles since soft reset, saturating
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      hi_cnt <= !done_flag ? '0 : (&hi_cnt ? hi_cnt : hi_cnt + 6'h01);
      idle_cnt <= soft_rst ? '0 : (&idle_cnt ? idle_cnt : idle_cnt + 10'h001);
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  timeout_reset_a: assert property (timeout_hit |=> !in_cmd && bit_cnt == 6'h00) // RULE1
    else $error("stalled clock did not reset interface");
  cs_reset_a: assert property (ser.cs_n |=> !in_cmd && !rd_mode) // RULE3
    else $error("chip select high did not reset interface");
  din_capture_a: assert property (sclk_fall && in_cmd && !iface_rst |=> // RULE4
      cmd_sh[0] == $past(ser.din))
    else $error("data-in not captured on falling edge");
  stop_cancel_a: assert property (state == ST_WINDOW && stop_lvl && !soft_rst // RULE7
      |=> state == ST_IDLE && !done_flag)
    else $error("early stop did not cancel next conversion");
  late_stop_a: assert property (state == ST_WINDOW && win_end && !stop_lvl && !soft_rst // RULE8
      |=> state == ST_CONV && done_flag)
    else $error("next conversion did not start after window");
  done_high_a: assert property ($fell(done_flag) |-> hi_cnt >= 6'(`ACC_DONE_HIGH_MIN)) // RULE9
    else $error("done flag high too short");
  settle_wait_a: assert property ($rose(state == ST_CONV) // RULE10
      |-> idle_cnt >= 10'(`ACC_SETTLE_CYC))
    else $error("conversion started before settle time");
  start_lat_a: assert property (state == ST_IDLE && start_req && !soft_rst // RULE11
      |-> ##[1:2] done_flag)
    else $error("done flag late after start");
  pin_mux_a: assert property (!in_cmd |=> DOUT_DONE_O == $past(done_flag)) // RULE12
    else $error("pin not showing done flag outside frame");
  to_restart_a: assert property (sclk_edge || ser.cs_n |=> to_cnt == '0) // RULE13
    else $error("timeout count not restarted");

  conv_done_c: cover property ($fell(done_flag));
  win_cancel_c: cover property (state == ST_WINDOW && stop_lvl);
  win_cont_c: cover property (state == ST_WINDOW && win_end && !stop_lvl);
  read_c: cover property (cmd_read);
endmodule

// ---- rtl/acc_pkg.sv ----
// types shared by the conversion control block
package acc_pkg;
  // pins that arrive from the host, grouped for synchronising
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic rst_n;
    logic start;
    logic to_en;
    logic cont;
  } acc_pins_t;
  // conversion sequencer states
  typedef enum logic [1:0] {ST_SETTLE, ST_IDLE, ST_CONV, ST_WINDOW} acc_state_t;
endpackage

// ---- rtl/acc_regs.svh ----
// timing constants and command codes of the conversion control block
// How it works
// RULE1: stalled serial clock auto-resets interface after timeout
// RULE2: host keeps serial clock above 1 kHz
// RULE3: chip select high resets the serial interface
// RULE4: data-in captured on serial clock falling edge
// RULE5: host holds reset low four clock periods
// RULE6: host keeps start phases four periods each
// RULE7: stop within 100 periods cancels next conversion
// RULE8: stop after 150 periods lets next conversion run
// RULE9: done flag stays high at least 16 periods
// RULE10: wait 512 periods after reset before converting
// RULE11: done flag rises within two periods of start
// RULE12: pin carries done flag outside a command
// RULE13: timeout count restarts on edges and chip select
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
// master-clock periods for a stalled serial clock to reset the interface
`define ACC_TIMEOUT_CYC 65540
// stop-request window after the done flag falls, in master-clock periods
`define ACC_STOP_WIN 100
// synchroniser and output-register delay of a stop, added to the window
`define ACC_SYNC_LAT 4
// synchroniser reset image: chip select high, every other pin low
`define ACC_PIN_RST 7'h20
// earliest stop-request that must still let the next conversion run
`define ACC_CONT_MIN 150
// least high time of the done flag
`define ACC_DONE_HIGH_MIN 16
// settle time after a reset before the first conversion
`define ACC_SETTLE_CYC 512
// most periods from start request to done flag high
`define ACC_START_LAT 2
// conversion length in master-clock periods, never below the high minimum
`define ACC_CONV_CYC 64
// frame layout
`define ACC_CMD_BITS 8
`define ACC_DATA_BITS 24
// command opcodes, values arbitrary
`define ACC_OP_START 8'h08
`define ACC_OP_STOP 8'h0a
`define ACC_OP_RESET 8'h06
`define ACC_OP_READ 8'h12
`endif

// ---- rtl/acc_sync.sv ----
// two-stage synchroniser for host pins
module acc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta; // first stage, read only by q_o

  // plain two-flop chain, constant reset value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ---- verif/acc_ctrl_tb.sv ----
// self-checking bench of the converter control block
`include "acc_regs.svh"
module acc_ctrl_tb import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO_CYC = 40; // shortened stall limit keeps the run short
  localparam int CONV = 64; // conversion length handed to the design
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reset_n = 1'b1;
  logic start = 1'b0;
  logic to_en = 1'b0;
  logic cont = 1'b0;
  logic sclk, cs_n, din, dout, oe_n, flag, rd_valid;
  logic fl; // flag level seen just before a stop request
  logic [23:0] rd_data;
  logic [23:0] exp_q[$]; // expected read results, oldest first
  logic [31:0] lfsr = 32'h5cae;
  int error_cnt = 0;
  int samples_checked = 0;
  int n = 0; // conversions the stimulus should have caused
  int w;
  int w2;
  always #4 clk = ~clk;
  acc_host u_acc_host (.clk_i(clk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n),
    .din_o(din), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  acc_ctrl #(.TIMEOUT_CYC(TO_CYC), .CONV_CYC(CONV)) u_acc_ctrl (.REF_CLK_I(clk),
    .NRST_I(nrst), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .RESET_N_I(reset_n),
    .START_I(start), .TIMEOUT_EN_I(to_en), .CONT_MODE_I(cont), .DOUT_DONE_O(dout),
    .DOUT_DONE_OE_N_O(oe_n), .DONE_FLAG_O(flag));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bounded wait for the done flag to reach v; k = edges spent
  task automatic wait_flag(input logic v, input int lim, output int k);
    k = 0;
    while (flag !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask
  // read of the conversion counter; pin must go back to the flag after
  task automatic rd();
    exp_q.push_back(n[23:0]);
    u_acc_host.frame(`ACC_OP_READ, 8, 24, 1'b0);
    chk_bit(oe_n, 1'b1, "pin still driven");
    chk_bit(dout, flag, "pin not showing flag");
  endtask
  // flag high after reset; a start inside the settle time must not convert
  task automatic settle_chk();
    wait_flag(1'b1, 8, w);
    chk_bit(flag, 1'b1, "flag low after reset");
    // start phases held eight cycles each
    start <= 1'b1;
    cyc(8);
    start <= 1'b0;
    wait_flag(1'b0, 520, w);
    chk_bit(w == 520, 1'b1, "converted inside settle");
    // once settled the same pulse must convert
    start <= 1'b1;
    cyc(8);
    start <= 1'b0;
    wait_flag(1'b0, 80, w);
    chk_bit(flag, 1'b0, "no conversion after settle");
  endtask
  // pin start in continuous mode; stop k edges after the flag falls
  task automatic cont_run(input int k, output int kr, output logic fl_o);
    start <= 1'b1;
    wait_flag(1'b1, 8, kr);
    chk_bit(kr <= 5, 1'b1, "start latency from low flag");
    wait_flag(1'b0, 80, kr);
    cyc(k);
    fl_o = flag;
    start <= 1'b0;
    // a conversion already running must finish before the run is over
    wait_flag(1'b0, 80, kr);
    wait_flag(1'b1, 200, kr);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read monitor: each finished read takes the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_bit(1'b1, 1'b0, "unexpected read");
      else chk_word(rd_data, exp_q.pop_front());
      chk_bit(oe_n, 1'b0, "pin not driven in frame");
    end
  end
  // watchdog sized well beyond the planned sequence
  initial begin
    cyc(20000);
    error_cnt++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    chk_bit(flag, 1'b1, "flag in reset");
    chk_bit(oe_n, 1'b1, "enable in reset");
    nrst <= 1'b1;
    // a start inside the settle time must be dropped, not queued
    cyc(100);
    start <= 1'b1;
    cyc(6);
    start <= 1'b0;
    cyc(500);
    rd();
    // single conversion by pin: latency and flag high time
    @(posedge clk);
    start <= 1'b1;
    wait_flag(1'b1, 8, w);
    chk_bit(w <= 5, 1'b1, "start latency");
    wait_flag(1'b0, 80, w2);
    chk_bit(w + w2 >= CONV + 1 && w + w2 <= CONV + 5, 1'b1, "busy time");
    start <= 1'b0;
    n = 1;
    // early stop cancels the next conversion
    cont <= 1'b1;
    lfsr = rnd(lfsr);
    cyc(10);
    cont_run(10 + int'(lfsr[5:0]), w, fl);
    chk_bit(fl, 1'b0, "next conversion began early");
    chk_bit(w == 200, 1'b1, "early stop ignored");
    // late stop: next conversion already runs, then the run ends
    lfsr = rnd(lfsr);
    cont_run(150 + int'(lfsr[3:0]), w, fl);
    chk_bit(fl, 1'b1, "next conversion did not run");
    chk_bit(w == 200, 1'b1, "run did not end");
    n = 4;
    // start and stop by command, stop inside the window
    u_acc_host.frame(`ACC_OP_START, 8, 0, 1'b0);
    chk_bit(flag, 1'b1, "start command");
    wait_flag(1'b0, 80, w);
    u_acc_host.frame(`ACC_OP_STOP, 8, 0, 1'b0);
    wait_flag(1'b1, 200, w);
    chk_bit(w == 200, 1'b1, "stop command ignored");
    n = 5;
    cont <= 1'b0;
    // partial frame cut by select high, then a whole start
    u_acc_host.frame(`ACC_OP_READ, 4, 0, 1'b0);
    u_acc_host.frame(`ACC_OP_START, 8, 0, 1'b0);
    chk_bit(flag, 1'b1, "frame after select");
    wait_flag(1'b0, 80, w);
    // partial frame left stalled with select low until time-out
    to_en <= 1'b1;
    u_acc_host.frame(`ACC_OP_READ, 4, 0, 1'b1);
    cyc(TO_CYC + 10);
    u_acc_host.frame(`ACC_OP_START, 8, 0, 1'b0);
    chk_bit(flag, 1'b1, "frame after time-out");
    wait_flag(1'b0, 80, w);
    n = 7;
    rd();
    // reset by command, then by pin held low four cycles
    u_acc_host.frame(`ACC_OP_RESET, 8, 0, 1'b0);
    settle_chk();
    // reset pin low for exactly the four-cycle minimum
    reset_n <= 1'b0;
    cyc(4);
    reset_n <= 1'b1;
    settle_chk();
    cyc(10);
    results();
  end
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule

// ---- verif/acc_host.sv ----
// host serial master model facing the converter control block
module acc_host import acc_pkg::*; (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic rd_valid_o,
  output logic [23:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: clock parked low, chip select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame: nop opcode bits, ndat read bits; keep leaves select low (stall)
  task automatic frame(input logic [7:0] op, input int nop, input int ndat, input bit keep);
    logic [23:0] sh;
    sh = '0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    // 64 ns clock period, far above the slowest allowed rate
    for (int i = 0; i < nop + ndat; i++) begin
      // bit set with the rise, held four cycles past the fall
      din_o <= (i < nop) ? op[7 - i] : 1'b0;
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      // read bit sampled mid low phase, well clear of its update
      if (i >= nop) sh = {sh[22:0], dout_i};
      repeat (2) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    // released data line shows the inverse, not a stale value
    din_o <= ~din_o;
    // select held high six cycles, over the 25 ns minimum
    if (!keep) cs_n_o <= 1'b1;
    if (ndat > 0) begin
      rd_data_o <= sh;
      rd_valid_o <= 1'b1;
    end
    @(posedge clk_i);
    rd_valid_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule
